// ### logic/smo_defs.vh
// Purpose: shared constants of the serial measurement output block
// Assumes: included by bare name from every design file
// Notes: definitions only
`ifndef SMO_DEFS_VH
`define SMO_DEFS_VH
// apb register byte addresses
`define SMO_ADDR_CTRL 12'h000
`define SMO_ADDR_STATUS 12'h004
`define SMO_ADDR_SENT 12'h008
`define SMO_ADDR_SKIP 12'h00C
// control register fields
`define SMO_CTRL_IFACE 0
`define SMO_CTRL_ASCII 1
`define SMO_CTRL_BAUD_LO 2
`define SMO_CTRL_PAR_EN 5
`define SMO_CTRL_PAR_ODD 6
`define SMO_CTRL_TWO_STOP 7
`define SMO_CTRL_SEGS_LO 8
`define SMO_CTRL_CUSTOM 10
`define SMO_CTRL_ENABLE 11
`define SMO_CTRL_RESTORE 31
// single-ended, 115.2 kBaud, variant frame, enabled
`define SMO_CTRL_RESET 32'h0000080C
`define SMO_CTRL_MASK 32'h00000FFF
// baud select codes
`define SMO_BAUD_SEL_9K6 3'h0
`define SMO_BAUD_SEL_19K2 3'h1
`define SMO_BAUD_SEL_38K4 3'h2
`define SMO_BAUD_SEL_115K2 3'h3
`define SMO_BAUD_SEL_691K2 3'h4
// baud rates in baud
`define SMO_BAUD_9K6 9600
`define SMO_BAUD_19K2 19200
`define SMO_BAUD_38K4 38400
`define SMO_BAUD_115K2 115200
`define SMO_BAUD_691K2 691200
// send one measurement in n
`define SMO_SKIP_9K6 4'h9
`define SMO_SKIP_19K2 4'h6
`define SMO_SKIP_38K4 4'h3
`define SMO_SKIP_FULL 4'h1
// characters and codes
`define SMO_CHR_TAB 8'h09
`define SMO_CHR_CR 8'h0D
`define SMO_CHR_ZERO 8'h30
`define SMO_ERR_FLOOR 16'hFFF0
`define SMO_TAG_LOW 2'h0
`define SMO_TAG_MID 2'h1
`define SMO_TAG_HIGH 2'h2
`define SMO_DIGITS 3'h5
`define SMO_CLK_HZ 200000000
`endif

// ### logic/smo_uart_tx.v
// Purpose: one-character asynchronous serialiser
// Assumes: div is the clock count per bit, at least 1
// Notes: busy covers the whole frame including the last stop bit
`timescale 1ns/1ps
`include "smo_defs.vh"
module smo_uart_tx (
  input wire pclk,
  input wire presetn,
  input wire [15:0] div,
  input wire par_en,
  input wire par_odd,
  input wire two_stop,
  input wire load,
  input wire [7:0] data,
  output reg txd,
  output reg busy
);
  reg [10:0] sh; // bits still to go, lsb next
  reg [3:0] left; // bits after the current one
  reg [15:0] cnt; // clocks left in current bit
  wire par_bit = par_odd ? ~^data : ^data;
  // load a frame, then step one bit per div clocks
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh <= 11'h7FF;
      left <= 4'h0;
      cnt <= 16'h0000;
      busy <= 1'b0;
      txd <= 1'b1;
    end
    else if (!busy)
    begin
      if (load)
      begin
        txd <= 1'b0; // start bit
        busy <= 1'b1;
        cnt <= div - 16'h0001;
        if (par_en)
          sh <= {2'b11, par_bit, data};
        else
          sh <= {3'b111, data};
        left <= 4'h9 + {3'h0, par_en} + {3'h0, two_stop};
      end
    end
    else if (cnt != 16'h0000)
      cnt <= cnt - 16'h0001;
    else if (left == 4'h0)
      busy <= 1'b0; // last stop bit fully out
    else
    begin
      txd <= sh[0];
      sh <= {1'b1, sh[10:1]};
      left <= left - 4'h1;
      cnt <= div - 16'h0001;
    end
  end
endmodule

// ### logic/smo_bin2dec.v
// Purpose: 16-bit binary to five decimal digits
// Assumes: start is ignored while busy
// Notes: shift and add three, one bit per clock, 16 clocks
`timescale 1ns/1ps
`include "smo_defs.vh"
module smo_bin2dec (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [15:0] value,
  output reg [19:0] digits,
  output reg busy
);
  reg [15:0] bin; // bits not yet shifted in
  reg [4:0] cnt; // shifts left
  wire [19:0] adj; // digits after the add-three step
  genvar g;
  // each nibble of five or more gets three added before the shift
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : gen_adj
      assign adj[4*g+3:4*g] = (digits[4*g+3:4*g] > 4'h4) ?
        digits[4*g+3:4*g] + 4'h3 : digits[4*g+3:4*g];
    end
  endgenerate
  // shift one bit in per clock
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bin <= 16'h0000;
      cnt <= 5'h00;
      digits <= 20'h00000;
      busy <= 1'b0;
    end
    else if (!busy)
    begin
      if (start)
      begin
        bin <= value;
        digits <= 20'h00000;
        cnt <= 5'h10;
        busy <= 1'b1;
      end
    end
    else
    begin
      digits <= {adj[18:0], bin[15]};
      bin <= {bin[14:0], 1'b0};
      cnt <= cnt - 5'h01;
      if (cnt == 5'h01)
        busy <= 1'b0;
    end
  end
endmodule

// ### logic/smo_top.v
// Purpose: frames measurement results onto one asynchronous serial line
// Assumes: meas_valid is a one-clock strobe with all segment values
// Notes: registers reached over apb, zero wait states
// Notes on behaviour
// - one serial variant active, chosen by config
// - reset: single-ended, 115.2 kBaud
// - binary word: low, middle, high byte
// - below 115.2 kBaud skip, never queue
// - every 3rd, 6th, 9th at slow rates
// - single-ended 9.6 to 115.2, default 8N2
// - differential to 691.2, default 8N1, all sent
// - eight data bits, parity, 1/2 stop
// - config picks binary or ascii
// - ascii record: five digits first, continuous
// - field holds 0 to 65535 decimal
// - one more field per segment, four max
// - tab between fields
// - carriage return ends each record
// - two top bits tag byte position
// - errored measurement shows 65520 or more
// - segment bits in high byte
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "smo_defs.vh"
module smo_top #(
  parameter CLK_HZ = `SMO_CLK_HZ
) (
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // measurement input
  input wire meas_valid,
  input wire [15:0] meas_seg0,
  input wire [15:0] meas_seg1,
  input wire [15:0] meas_seg2,
  input wire [15:0] meas_seg3,
  input wire [3:0] meas_err,
  // serial line outputs
  output reg se_txd,
  output reg diff_txd_p,
  output reg diff_txd_n
);
  // one-hot states of the record sequencer
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_CONV = 4'b0010;
  localparam [3:0] S_LOAD = 4'b0100;
  localparam [3:0] S_WAIT = 4'b1000;

  // bit clocks per baud, rounded down from the clock rate
  localparam integer DIV_9K6 = CLK_HZ / `SMO_BAUD_9K6;
  localparam integer DIV_19K2 = CLK_HZ / `SMO_BAUD_19K2;
  localparam integer DIV_38K4 = CLK_HZ / `SMO_BAUD_38K4;
  localparam integer DIV_115K2 = CLK_HZ / `SMO_BAUD_115K2;
  localparam integer DIV_691K2 = CLK_HZ / `SMO_BAUD_691K2;

  reg [31:0] ctrl; // control register
  reg [15:0] sent_cnt; // records sent, wraps
  reg [15:0] skip_cnt; // measurements skipped, wraps
  reg [3:0] state; // sequencer state
  reg [3:0] dec_cnt; // measurements until the next one sent
  reg [63:0] hold; // latched segment values
  reg [1:0] seg; // segment being sent
  reg [2:0] pos; // character within the field
  reg [1:0] seg_last; // last segment of the latched record
  reg rec_ascii; // format latched for the record
  reg [31:0] div_full; // divisor before narrowing
  reg [3:0] skip_n; // decimation factor
  reg [7:0] tx_byte; // character presented to the serialiser
  reg [31:0] rd_data; // read mux
  reg rd_ok; // address is mapped
  reg conv_seen; // converter started for this field
  wire [15:0] tx_div; // narrowed divisor
  wire tx_load; // serialiser load strobe
  wire tx_txd; // serialiser line level
  wire tx_busy; // serialiser frame in progress
  wire conv_busy; // converter working
  wire [19:0] conv_digits; // five bcd digits
  wire conv_start; // converter start strobe
  wire [15:0] cur_val; // value of the current segment
  wire is_diff; // differential variant chosen
  wire [2:0] baud_sel; // effective baud code
  wire last_pos; // last character of a field
  wire last_seg; // last field of a record
  wire frame_par_en; // effective parity enable
  wire frame_two_stop; // effective stop bit count
  wire take; // start a record this cycle
  wire drop; // measurement discarded this cycle
  wire wr_acc; // apb write access phase
  wire rd_setup; // apb read setup phase

  // force errored values into the error band
  function [15:0] clamp_err;
    input [15:0] v;
    input err;
    begin
      if (err && v < `SMO_ERR_FLOOR)
        clamp_err = `SMO_ERR_FLOOR;
      else
        clamp_err = v;
    end
  endfunction

  // limit the baud code to what the active variant supports
  function [2:0] eff_baud;
    input [2:0] code;
    input diff;
    begin
      if (code > `SMO_BAUD_SEL_691K2)
        eff_baud = `SMO_BAUD_SEL_115K2;
      else if (code == `SMO_BAUD_SEL_691K2 && !diff)
        eff_baud = `SMO_BAUD_SEL_115K2;
      else
        eff_baud = code;
    end
  endfunction

  // variant select, single line active at a time
  assign is_diff = ctrl[`SMO_CTRL_IFACE];
  assign baud_sel = eff_baud(ctrl[`SMO_CTRL_BAUD_LO+2:`SMO_CTRL_BAUD_LO],
    is_diff);

  // frame: variant default unless custom framing is chosen
  assign frame_par_en = ctrl[`SMO_CTRL_CUSTOM] &
    ctrl[`SMO_CTRL_PAR_EN];
  assign frame_two_stop = ctrl[`SMO_CTRL_CUSTOM] ?
    ctrl[`SMO_CTRL_TWO_STOP] : !is_diff;

  // divisor and decimation factor from the baud code
  always @*
  begin
    div_full = DIV_115K2;
    skip_n = `SMO_SKIP_FULL;
    case (baud_sel)
      `SMO_BAUD_SEL_9K6:
      begin
        div_full = DIV_9K6;
        skip_n = `SMO_SKIP_9K6;
      end
      `SMO_BAUD_SEL_19K2:
      begin
        div_full = DIV_19K2;
        skip_n = `SMO_SKIP_19K2;
      end
      `SMO_BAUD_SEL_38K4:
      begin
        div_full = DIV_38K4;
        skip_n = `SMO_SKIP_38K4;
      end
      `SMO_BAUD_SEL_691K2:
      begin
        div_full = DIV_691K2;
        skip_n = `SMO_SKIP_FULL;
      end
      default:
      begin
        div_full = DIV_115K2;
        skip_n = `SMO_SKIP_FULL;
      end
    endcase
  end
  assign tx_div = div_full[15:0];

  // decimation grid runs on every strobe; a slot is only used when idle
  assign take = meas_valid && dec_cnt == 4'h0 && state == S_IDLE &&
    ctrl[`SMO_CTRL_ENABLE];
  assign drop = meas_valid && !take;

  // current segment value and record position
  assign cur_val = hold[{seg, 4'h0} +: 16];
  assign last_pos = rec_ascii ? (pos == `SMO_DIGITS) : (pos == 3'h2);
  assign last_seg = (seg == seg_last);

  // character for the current position
  always @*
  begin
    tx_byte = `SMO_CHR_CR;
    if (rec_ascii)
    begin
      case (pos)
        3'h0: tx_byte = `SMO_CHR_ZERO + {4'h0, conv_digits[19:16]};
        3'h1: tx_byte = `SMO_CHR_ZERO + {4'h0, conv_digits[15:12]};
        3'h2: tx_byte = `SMO_CHR_ZERO + {4'h0, conv_digits[11:8]};
        3'h3: tx_byte = `SMO_CHR_ZERO + {4'h0, conv_digits[7:4]};
        3'h4: tx_byte = `SMO_CHR_ZERO + {4'h0, conv_digits[3:0]};
        default:
          // tab between fields, return at the end
          if (last_seg)
            tx_byte = `SMO_CHR_CR;
          else
            tx_byte = `SMO_CHR_TAB;
      endcase
    end
    else
    begin
      case (pos)
        3'h0: tx_byte = {`SMO_TAG_LOW, cur_val[5:0]};
        3'h1: tx_byte = {`SMO_TAG_MID, cur_val[11:6]};
        default: tx_byte = {`SMO_TAG_HIGH, seg, cur_val[15:12]};
      endcase
    end
  end

  // strobes towards the two helpers
  assign tx_load = (state == S_LOAD) && !tx_busy;
  assign conv_start = (state == S_CONV) && !conv_busy && !conv_seen;

  // record sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_IDLE;
      dec_cnt <= 4'h0;
      hold <= 64'h0;
      seg <= 2'h0;
      pos <= 3'h0;
      seg_last <= 2'h0;
      rec_ascii <= 1'b0;
      conv_seen <= 1'b0;
      sent_cnt <= 16'h0000;
      skip_cnt <= 16'h0000;
    end
    else
    begin
      // decimation counter advances on each measurement
      if (meas_valid)
      begin
        if (dec_cnt == 4'h0 || dec_cnt >= skip_n)
          dec_cnt <= skip_n - 4'h1;
        else
          dec_cnt <= dec_cnt - 4'h1;
      end
      // skipped strobes are counted, never stored
      if (drop)
        skip_cnt <= skip_cnt + 16'h0001;
      case (state)
        S_IDLE:
          if (take)
          begin
            hold <= {clamp_err(meas_seg3, meas_err[3]),
              clamp_err(meas_seg2, meas_err[2]),
              clamp_err(meas_seg1, meas_err[1]),
              clamp_err(meas_seg0, meas_err[0])};
            seg_last <= ctrl[`SMO_CTRL_SEGS_LO+1:`SMO_CTRL_SEGS_LO];
            rec_ascii <= ctrl[`SMO_CTRL_ASCII];
            seg <= 2'h0;
            pos <= 3'h0;
            if (ctrl[`SMO_CTRL_ASCII])
              state <= S_CONV;
            else
              state <= S_LOAD;
          end
        S_CONV:
          // start once, then wait for the digits to settle
          if (conv_start)
            conv_seen <= 1'b1;
          else if (conv_seen && !conv_busy)
          begin
            // without the flag a finished pass would restart forever
            conv_seen <= 1'b0;
            state <= S_LOAD;
          end
        S_LOAD:
          if (tx_load)
            state <= S_WAIT;
        S_WAIT:
          // the whole character, stop bits too, must be out
          if (!tx_busy)
          begin
            if (!last_pos)
            begin
              pos <= pos + 3'h1;
              state <= S_LOAD;
            end
            else if (!last_seg)
            begin
              seg <= seg + 2'h1;
              pos <= 3'h0;
              if (rec_ascii)
                state <= S_CONV;
              else
                state <= S_LOAD;
            end
            else
            begin
              sent_cnt <= sent_cnt + 16'h0001;
              state <= S_IDLE;
            end
          end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // line outputs; the unselected variant rests at mark level
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      se_txd <= 1'b1;
      diff_txd_p <= 1'b1;
      diff_txd_n <= 1'b0;
    end
    else
    begin
      se_txd <= is_diff ? 1'b1 : tx_txd;
      diff_txd_p <= is_diff ? tx_txd : 1'b1;
      diff_txd_n <= is_diff ? !tx_txd : 1'b0;
    end
  end

  // apb: no wait states, errors on unmapped addresses
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  // read mux and address decode
  always @*
  begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    if (paddr == `SMO_ADDR_CTRL)
      rd_data = ctrl;
    else if (paddr == `SMO_ADDR_STATUS)
      rd_data = {24'h000000, state, 1'b0, is_diff, conv_busy, tx_busy};
    else if (paddr == `SMO_ADDR_SENT)
      rd_data = {16'h0000, sent_cnt};
    else if (paddr == `SMO_ADDR_SKIP)
      rd_data = {16'h0000, skip_cnt};
    else
      rd_ok = 1'b0;
  end
  assign pslverr = psel && penable && !rd_ok;

  // control writes; restore brings back the reset settings
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `SMO_CTRL_RESET;
      prdata <= 32'h00000000;
    end
    else
    begin
      if (rd_setup)
        prdata <= rd_data;
      if (wr_acc && paddr == `SMO_ADDR_CTRL)
      begin
        if (pwdata[`SMO_CTRL_RESTORE])
          ctrl <= `SMO_CTRL_RESET;
        else
          ctrl <= pwdata & `SMO_CTRL_MASK;
      end
    end
  end

  // character serialiser, shared by both variants
  smo_uart_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .div(tx_div),
    .par_en(frame_par_en),
    .par_odd(ctrl[`SMO_CTRL_PAR_ODD]),
    .two_stop(frame_two_stop),
    .load(tx_load),
    .data(tx_byte),
    .txd(tx_txd),
    .busy(tx_busy)
  );

  // decimal converter for ascii fields
  smo_bin2dec u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .start(conv_start),
    .value(cur_val),
    .digits(conv_digits),
    .busy(conv_busy)
  );
endmodule

// ### dv/smo_checker.sv
// Purpose: port-level checks of the serial output block
// Assumes: bound to smo_top, single clock domain
// Notes: bit-length checks use the fastest rate of each line
`timescale 1ns/1ps
module smo_checker #(
  parameter CLK_HZ = 200000000
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire se_txd,
  input wire diff_txd_p,
  input wire diff_txd_n
);
  localparam int MIN_SE = CLK_HZ / 115200; // shortest single-ended bit
  localparam int MIN_DF = CLK_HZ / 691200; // shortest differential bit
  logic [15:0] se_lo; // length of current low run
  logic [15:0] se_hi; // length of current high run, saturating
  logic [15:0] df_lo; // low run on the differential line
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // run counters; high run starts saturated so reset idle is long enough
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      se_lo <= 16'h0000;
      se_hi <= 16'hFFFF;
      df_lo <= 16'h0000;
    end
    else
    begin
      se_lo <= se_txd ? 16'h0000 : se_lo + 16'h0001;
      df_lo <= diff_txd_p ? 16'h0000 : df_lo + 16'h0001;
      if (!se_txd)
        se_hi <= 16'h0000;
      else if (se_hi != 16'hFFFF)
        se_hi <= se_hi + 16'h0001;
    end
  end
  sequence s_release;
    $rose(presetn);
  endsequence
  sequence s_se_start;
    $fell(se_txd);
  endsequence
  AST_RESET_IDLE: assert property (
    s_release |-> se_txd && diff_txd_p && !diff_txd_n)
    else $error("line not idle after reset");
  AST_DIFF_COMPL: assert property (diff_txd_n == !diff_txd_p)
    else $error("differential pair not complementary");
  AST_ONE_VARIANT: assert property (!diff_txd_p |-> se_txd)
    else $error("both line variants active");
  AST_SE_QUIET: assert property (s_se_start |=> diff_txd_p [*3])
    else $error("differential line moved during frame");
  AST_SE_BIT: assert property ($rose(se_txd) |-> se_lo >= MIN_SE)
    else $error("single-ended bit too short");
  AST_SE_STOP: assert property (s_se_start |-> se_hi >= MIN_SE)
    else $error("stop or high bit too short");
  AST_DF_BIT: assert property ($rose(diff_txd_p) |-> df_lo >= MIN_DF)
    else $error("differential bit too short");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access phase");
  AST_READY: assert property ($rose(penable) && psel |-> pready)
    else $error("access phase not answered");
endmodule
bind smo_top smo_checker #(.CLK_HZ(CLK_HZ)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .se_txd(se_txd),
  .diff_txd_p(diff_txd_p), .diff_txd_n(diff_txd_n));

// ### dv/smo_host_rx.sv
// Purpose: host receiver of the measurement stream
// Assumes: frame settings change only while the line is idle
// Notes: samples mid-bit on pclk; passive listener
`timescale 1ns/1ps
module smo_host_rx (
  input wire logic pclk,
  input wire logic rxd,
  input wire logic [15:0] div,
  input wire logic two_stop,
  input wire logic par_en,
  input wire logic par_odd,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_err
);
  logic [7:0] sh; // data bits, lsb first
  logic bad; // any framing fault in this character
  initial
  begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_err = 1'b0;
  end
  // one character per pass: start, data, parity, stop
  always
  begin
    @(negedge rxd);
    repeat (div / 2) @(posedge pclk);
    bad = (rxd !== 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      repeat (div) @(posedge pclk);
      sh[i] = rxd;
    end
    if (par_en)
    begin
      repeat (div) @(posedge pclk);
      bad = bad | (rxd !== (^sh ^ par_odd));
    end
    repeat (div) @(posedge pclk);
    bad = bad | (rxd !== 1'b1);
    // second stop sample catches a start bit that came too early
    if (two_stop)
    begin
      repeat (div) @(posedge pclk);
      bad = bad | (rxd !== 1'b1);
    end
    rx_byte <= sh;
    rx_err <= bad;
    rx_valid <= 1'b1;
    @(posedge pclk);
    rx_valid <= 1'b0;
  end
endmodule

// ### dv/smo_top_bench.sv
// Purpose: self-checking bench for the serial output block
// Assumes: short clock parameter, 20 cycles a bit at 115.2k
// Notes: driver queues expected bytes, watcher pops and compares
`timescale 1ns/1ps
`include "smo_defs.vh"
module smo_top_bench;
  localparam int CLK = 2304000; // scaled clock rate for the design
  localparam int LIMIT = 95000; // cycle ceiling of the run
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic meas_valid = 1'b0;
  logic [15:0] segv [4] = '{default: 16'h0000}; // segment values
  logic [3:0] errv = 4'h0; // per-segment error flags
  logic se_txd;
  logic diff_txd_p;
  logic diff_txd_n;
  logic diff_sel = 1'b0; // host listens to the differential line
  logic [15:0] hdiv = 16'h0014; // host cycles per bit
  logic two_stop = 1'b1;
  logic par_en = 1'b0;
  logic par_odd = 1'b0;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic rx_err;
  logic [7:0] expq [$]; // expected bytes, oldest first
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] rng = 32'hF53C4B6F;
  always #2.5 pclk = ~pclk;
  smo_top #(.CLK_HZ(CLK)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_valid(meas_valid),
    .meas_seg0(segv[0]), .meas_seg1(segv[1]), .meas_seg2(segv[2]),
    .meas_seg3(segv[3]), .meas_err(errv), .se_txd(se_txd),
    .diff_txd_p(diff_txd_p), .diff_txd_n(diff_txd_n));
  smo_host_rx u_host (
    .pclk(pclk), .rxd(diff_sel ? diff_txd_p : se_txd), .div(hdiv),
    .two_stop(two_stop), .par_en(par_en), .par_odd(par_odd),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_err(rx_err));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic fail(input string m);
    n_fail++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] x,
                          input string m);
    check_count++;
    if (g !== x)
      fail($sformatf("%s got %h want %h", m, g, x));
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] x);
    check_count++;
    if (g !== x)
      fail($sformatf("byte got %h want %h", g, x));
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
  endtask
  // host frame follows the control word written
  task automatic cfg(input logic [31:0] c, input logic ds, input int dv,
                     input logic ts, input logic pe, input logic po);
    wr(`SMO_ADDR_CTRL, c);
    diff_sel <= ds;
    hdiv <= 16'(dv);
    two_stop <= ts;
    par_en <= pe;
    par_odd <= po;
  endtask
  // expected record built from the current segment values
  task automatic push_exp(input int nseg, input logic asc);
    logic [15:0] v;
    int r;
    for (int i = 0; i < nseg; i++)
    begin
      v = (errv[i] && segv[i] < `SMO_ERR_FLOOR) ? `SMO_ERR_FLOOR : segv[i];
      if (!asc)
      begin
        expq.push_back({`SMO_TAG_LOW, v[5:0]});
        expq.push_back({`SMO_TAG_MID, v[11:6]});
        expq.push_back({`SMO_TAG_HIGH, i[1:0], v[15:12]});
      end
      else
      begin
        for (r = 10000; r > 0; r = r / 10)
          expq.push_back(8'(`SMO_CHR_ZERO + (v / r) % 10));
        expq.push_back(i == nseg - 1 ? `SMO_CHR_CR : `SMO_CHR_TAB);
      end
    end
  endtask
  // one measurement strobe, optionally with fresh random values
  task automatic strobe(input logic fresh);
    @(posedge pclk);
    for (int i = 0; i < 4; i++)
    begin
      rng = xs(rng);
      if (fresh)
        segv[i] <= rng[15:0];
    end
    meas_valid <= 1'b1;
    @(posedge pclk);
    meas_valid <= 1'b0;
  endtask
  // wait for all bytes, then let the last stop bits finish
  task automatic drain();
    while (expq.size() != 0) @(posedge pclk);
    repeat (4 * hdiv) @(posedge pclk);
  endtask
  // watcher: cycle ceiling and byte comparison
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      fail("run too long");
      complete_run();
    end
    if (rx_valid === 1'b1)
    begin
      if (rx_err !== 1'b0)
        fail("bad frame on line");
      if (expq.size() == 0)
        fail("unexpected byte");
      else
        chk_byte(rx_byte, expq.pop_front());
    end
  end
  initial
  begin
    logic [31:0] q;
    logic [31:0] w;
    logic [31:0] s0;
    logic [31:0] k0;
    logic e;
    int f;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SMO_ADDR_CTRL, q);
    chk_word(q, `SMO_CTRL_RESET, "ctrl reset");
    apb(1'b0, 12'h010, 32'h00000000, q, e);
    chk_word({31'h0, e}, 32'h00000001, "unmapped");
    rng = xs(rng);
    w = rng & `SMO_CTRL_MASK;
    wr(`SMO_ADDR_CTRL, w);
    rd(`SMO_ADDR_CTRL, q);
    chk_word(q, w, "ctrl readback");
    wr(`SMO_ADDR_CTRL, 32'h80000000);
    rd(`SMO_ADDR_CTRL, q);
    chk_word(q, `SMO_CTRL_RESET, "ctrl restore");
    // default frame; a strobe mid-record must be dropped
    strobe(1'b1);
    push_exp(1, 1'b0);
    repeat (10) @(posedge pclk);
    strobe(1'b1);
    drain();
    // errored values, low and already high
    errv <= 4'h1;
    for (int i = 0; i < 2; i++)
    begin
      segv[0] <= i ? 16'hFFF5 : 16'h0123;
      strobe(1'b0);
      push_exp(1, 1'b0);
      drain();
    end
    errv <= 4'h0;
    wr(`SMO_ADDR_CTRL, `SMO_CTRL_RESET | 32'h00000300);
    strobe(1'b1);
    push_exp(4, 1'b0);
    drain();
    // ascii, four fields, top value and zero padding
    wr(`SMO_ADDR_CTRL, `SMO_CTRL_RESET | 32'h00000302);
    segv[0] <= 16'hFFFF;
    segv[1] <= 16'h0007;
    strobe(1'b0);
    push_exp(4, 1'b1);
    drain();
    // slow rates send one strobe in nine, six, three
    for (int c = 0; c < 3; c++)
    begin
      f = c == 0 ? 9 : (c == 1 ? 6 : 3);
      cfg(32'h00000800 | (c << 2), 1'b0, CLK / (9600 << c), 1'b1, 0, 0);
      rd(`SMO_ADDR_SENT, s0);
      rd(`SMO_ADDR_SKIP, k0);
      repeat (18 / f) push_exp(1, 1'b0);
      repeat (18)
      begin
        strobe(1'b0);
        repeat (898) @(posedge pclk);
      end
      drain();
      rd(`SMO_ADDR_SENT, q);
      chk_word(q - s0, 32'(18 / f), "records sent");
      rd(`SMO_ADDR_SKIP, q);
      chk_word(q - k0, 32'(18 - 18 / f), "strobes skipped");
    end
    // differential at the top rate, every strobe sent, one stop bit
    cfg(32'h00000811, 1'b1, CLK / 691200, 1'b0, 1'b0, 1'b0);
    repeat (4)
    begin
      strobe(1'b1);
      push_exp(1, 1'b0);
      repeat (148) @(posedge pclk);
    end
    drain();
    // custom frame with even then odd parity, one stop bit
    for (int p = 0; p < 2; p++)
    begin
      cfg(32'h00000C2C | (p << 6), 1'b0, CLK / 115200, 1'b0, 1'b1, p[0]);
      strobe(1'b1);
      push_exp(1, 1'b0);
      drain();
    end
    complete_run();
  end
endmodule
